// [bench/csr_host_model.sv]
`timescale 1ns/10ps
`include "eth_csr_defs.svh"
module csr_host_model (
   input  wire logic                   ref_clk,
   input  wire logic                   reg_waitrequest,
   input  wire logic                   reg_readdata_valid,
   input  wire logic [`CSR_DATA_W-1:0] reg_readdata,
   output      logic [`CSR_ADDR_W-1:0] reg_addr,
   output      logic                   reg_read,
   output      logic                   reg_write,
   output      logic [`CSR_DATA_W-1:0] reg_writedata,
   output      logic                   timed_out
);
   initial begin
      reg_addr = 12'h000;
      reg_read = 1'b0;
      reg_write = 1'b0;
      reg_writedata = 32'h00000000;
      timed_out = 1'b0;
   end
   task automatic access(input logic wr, input logic [`CSR_ADDR_W-1:0] a,
                         input logic [`CSR_DATA_W-1:0] d, output logic [`CSR_DATA_W-1:0] q);
      int n;
      q = 32'h00000000;
      n = 0;
      reg_addr      <= a;
      reg_writedata <= d;
      reg_write     <= wr;
      reg_read      <= !wr;
      do begin
         @(negedge ref_clk);
         n++;
      end while (reg_waitrequest !== 1'b0 && n < 40);
      @(posedge ref_clk);
      reg_read      <= 1'b0;
      reg_write     <= 1'b0;
      // released lines must not keep their old value
      reg_addr      <= ~a;
      reg_writedata <= ~d;
      if (!wr) begin
         do begin
            @(negedge ref_clk);
            n++;
         end while (reg_readdata_valid !== 1'b1 && n < 44);
         q = reg_readdata;
      end
      if (n >= 40)
         timed_out = 1'b1;
      @(posedge ref_clk);
   endtask
endmodule

// [bench/eth_csr_chk.sv]
`timescale 1ns/10ps
`include "eth_csr_defs.svh"
module eth_csr_chk #(
   parameter int LANES = 4
) (
   input wire logic             ref_clk,
   input wire logic             nrst,
   input wire logic             csr_rst_n,
   input wire logic             tx_rst_n,
   input wire logic             reg_read,
   input wire logic             reg_write,
   input wire logic             reg_readdata_valid,
   input wire logic             reg_waitrequest,
   input wire logic [LANES-1:0] lane_cdr_locked,
   input wire logic [LANES-1:0] lane_tx_ready,
   input wire logic [LANES-1:0] lane_block_aligned,
   input wire logic             rx_markers_found,
   input wire logic             rx_deskew_done,
   input wire logic [LANES-1:0] rx_lane_ready,
   input wire logic             rx_remote_fault_seen,
   input wire logic             rx_ber_state,
   input wire logic             cdr_lock,
   input wire logic             tx_lanes_stable,
   input wire logic             rx_block_lock,
   input wire logic             receive_marker_aligned,
   input wire logic             rx_pcs_ready,
   input wire logic             remote_fault_status,
   input wire logic             receive_error_rate_high,
   input wire logic             recovered_clock_slow_a,
   input wire logic             recovered_clock_slow_b,
   input wire logic             block_ready
);
   wire rd_ok = reg_read && !reg_waitrequest;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   sequence rd_taken;
      rd_ok;
   endsequence
   sequence req_held;
      (reg_read || reg_write) && reg_waitrequest && csr_rst_n;
   endsequence
   port_silent_a: assert property (!csr_rst_n |-> reg_waitrequest)
      else $error("waitrequest low in global reset");
   read_valid_a: assert property (rd_taken |=> reg_readdata_valid)
      else $error("no valid after taken read");
   valid_cause_a: assert property (reg_readdata_valid |-> $past(rd_ok))
      else $error("valid without taken read");
   first_wait_a: assert property ($rose(reg_read || reg_write) |-> reg_waitrequest)
      else $error("request taken in first cycle");
   wait_bound_a: assert property (
      req_held ##1 ((reg_read || reg_write) && csr_rst_n) |-> !reg_waitrequest)
      else $error("request stalled too long");
   cdr_lock_a: assert property (!(&lane_cdr_locked) |=> !cdr_lock)
      else $error("lock without all lanes");
   slow_quiet_a: assert property (
      !cdr_lock |=> !(recovered_clock_slow_a || recovered_clock_slow_b))
      else $error("slow enable before lock");
   lanes_stable_a: assert property (!(&lane_tx_ready) |=> !tx_lanes_stable)
      else $error("lanes stable too early");
   block_lock_a: assert property (!(&lane_block_aligned) |=> !rx_block_lock)
      else $error("block lock too early");
   marker_lock_a: assert property (
      !(rx_markers_found && rx_deskew_done) |=> !receive_marker_aligned)
      else $error("marker lock too early");
   pcs_ready_a: assert property (!(&rx_lane_ready) |=> !rx_pcs_ready)
      else $error("pcs ready too early");
   remote_fault_a: assert property (!rx_remote_fault_seen |=> !remote_fault_status)
      else $error("remote fault without cause");
   err_rate_a: assert property (!rx_ber_state |=> !receive_error_rate_high)
      else $error("error rate high without cause");
   ready_drop_a: assert property ((!tx_rst_n || !csr_rst_n) |=> !block_ready)
      else $error("block ready during reset");
endmodule

bind eth_csr_port_and_status eth_csr_chk #(.LANES(LANES)) eth_csr_chk_i (.*);

// [bench/test_eth_csr_port_and_status.sv]
`timescale 1ns/10ps
`include "eth_csr_defs.svh"
module test_eth_csr_port_and_status;
   logic                   ref_clk = 1'b0;
   logic                   nrst = 1'b0;
   logic                   csr_rst_n = 1'b0;
   logic                   tx_rst_n = 1'b1;
   logic                   rx_rst_n = 1'b1;
   logic [3:0]             cdr = 4'h0;
   logic [3:0]             txr = 4'h0;
   logic [3:0]             bal = 4'h0;
   logic [3:0]             rxr = 4'h0;
   logic [5:0]             misc = 6'h00;
   wire logic [8:0]        st;
   logic                   sa;
   logic                   sb;
   logic [7:0]             pa;
   logic [7:0]             pb;
   logic [`CSR_ADDR_W-1:0] addr;
   logic [`CSR_DATA_W-1:0] wd;
   logic [`CSR_DATA_W-1:0] rdq;
   logic                   rd;
   logic                   wr_r;
   logic                   vld;
   logic                   wq;
   logic                   tmo;
   logic [31:0]            seed;
   int                     bad_count = 0;
   int                     checks_done = 0;
   int                     cyc = 0;

   always #25 ref_clk = ~ref_clk;

   eth_csr_port_and_status #(.LANES(4), .INIT_CYCLES(2), .REC_DIV_A(4), .REC_DIV_B(6))
   eth_csr_port_and_status_i (
      .ref_clk(ref_clk), .nrst(nrst), .csr_rst_n(csr_rst_n), .tx_rst_n(tx_rst_n),
      .rx_rst_n(rx_rst_n), .reg_addr(addr), .reg_read(rd), .reg_write(wr_r),
      .reg_writedata(wd), .reg_readdata(rdq), .reg_readdata_valid(vld),
      .reg_waitrequest(wq), .lane_cdr_locked(cdr), .lane_tx_ready(txr),
      .lane_block_aligned(bal), .rx_markers_found(misc[0]), .rx_deskew_done(misc[1]),
      .rx_lane_ready(rxr), .rx_local_problem(misc[2]), .rx_remote_fault_seen(misc[3]),
      .rx_ber_state(misc[4]), .stats_snapshot(misc[5]), .cdr_lock(st[0]),
      .recovered_clock_slow_a(sa), .recovered_clock_slow_b(sb), .tx_lanes_stable(st[1]),
      .rx_block_lock(st[2]), .receive_marker_aligned(st[3]), .rx_pcs_ready(st[4]),
      .local_fault_status(st[5]), .remote_fault_status(st[6]),
      .receive_error_rate_high(st[7]), .block_ready(st[8]));

   csr_host_model csr_host_model_i (
      .ref_clk(ref_clk), .reg_waitrequest(wq), .reg_readdata_valid(vld),
      .reg_readdata(rdq), .reg_addr(addr), .reg_read(rd), .reg_write(wr_r),
      .reg_writedata(wd), .timed_out(tmo));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [8:0] exp_st(input logic [3:0] c, t, b, r, input logic [5:0] m);
      return {1'b1, m[4], m[3], m[2], (&r) & m[0] & m[1] & (&b), m[0] & m[1], &b, &t, &c};
   endfunction

   task close_out;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      @(posedge ref_clk);
      csr_host_model_i.access(1'b1, a, d, q);
   endtask
   task rd_chk(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      @(posedge ref_clk);
      csr_host_model_i.access(1'b0, a, 32'h00000000, q);
      check(q, e);
   endtask
   task settle;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task await_ready;
      @(negedge ref_clk);
      for (int n = 0; n < 5 && st[8] !== 1'b1; n++)
         @(negedge ref_clk);
      check(st[8], 1'b1);
   endtask

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000 || tmo === 1'b1) begin
         bad_count++;
         close_out();
      end
   end

   initial begin
      seed = 32'h00011AEA;
      repeat (6) @(posedge ref_clk);
      nrst <= 1'b1;
      csr_rst_n <= 1'b1;
      await_ready();
      rd_chk(12'h300, 32'h00000002);
      rd_chk(12'h308, 32'h00000000);
      rd_chk(12'h946, 32'h00000000);
      rd_chk(12'h0F0, 32'h00000000);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         wr(12'h308, seed);
         rd_chk(12'h308, seed);
      end
      @(posedge ref_clk);
      misc <= 6'h0C;
      for (int m = 0; m < 4; m++) begin
         wr(12'h300, 32'(m));
         settle();
         check(st[5], m == 1 || m == 2);
         check(st[6], m == 2);
      end
      wr(12'h300, 32'h00000002);
      for (int i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         @(posedge ref_clk);
         cdr <= seed[3:0] | {4{seed[16]}};
         txr <= seed[7:4] | {4{seed[17]}};
         bal <= seed[11:8] | {4{seed[18]}};
         rxr <= seed[15:12] | {4{seed[19]}};
         misc <= {1'b0, seed[24:20]};
         settle();
         check(st, exp_st(cdr, txr, bal, rxr, misc));
      end
      @(posedge ref_clk);
      cdr <= 4'hF;
      settle();
      repeat (8) @(posedge ref_clk);
      pa = 8'h00;
      pb = 8'h00;
      repeat (12) begin
         @(negedge ref_clk);
         pa = pa + {7'h00, sa};
         pb = pb + {7'h00, sb};
      end
      check(pa, 32'h00000003);
      check(pb, 32'h00000002);
      @(posedge ref_clk);
      misc[5] <= 1'b1;
      rd_chk(12'h946, 32'h00000002);
      @(posedge ref_clk);
      misc[5] <= 1'b0;
      rd_chk(12'h946, 32'h00000000);
      @(posedge ref_clk);
      rx_rst_n <= 1'b0;
      wr(12'h308, 32'h0000C3C3);
      rd_chk(12'h308, 32'h0000C3C3);
      check({st[4:2], st[0]}, 4'h0);
      rx_rst_n <= 1'b1;
      tx_rst_n <= 1'b0;
      settle();
      check(st[8], 1'b0);
      @(posedge ref_clk);
      tx_rst_n <= 1'b1;
      await_ready();
      wr(12'h308, 32'h0000A5A5);
      wr(12'h300, 32'h00000030);
      settle();
      check(st[8], 1'b0);
      check(st[1], 1'b0);
      check({st[4:2], st[0]}, 4'h0);
      @(posedge ref_clk);
      csr_rst_n <= 1'b0;
      settle();
      check(st[8], 1'b0);
      @(posedge ref_clk);
      csr_rst_n <= 1'b1;
      await_ready();
      rd_chk(12'h300, 32'h00000002);
      rd_chk(12'h308, 32'h00000000);
      wr(12'h308, 32'h0000005A);
      nrst <= 1'b0;
      @(posedge ref_clk);
      nrst <= 1'b1;
      await_ready();
      rd_chk(12'h308, 32'h0000005A);
      close_out();
   end
endmodule

// [rtl/csr_if.sv]
`timescale 1ns/10ps
`include "eth_csr_defs.svh"

interface csr_if;
   logic                       wr_en;
   logic                       rd_en;
   logic [`CSR_ADDR_W-1:0]     addr;
   logic [`CSR_DATA_W-1:0]     wdata;
   logic [`CSR_DATA_W-1:0]     rdata;
   logic                       snap_on;
   logic [`STAT_W-1:0]         live_status;
   eth_csr_pkg::fault_mode_t   fault_mode;
   logic                       soft_tx_rst;
   logic                       soft_rx_rst;

   modport port (
      output wr_en, rd_en, addr, wdata, snap_on, live_status,
      input  rdata, fault_mode, soft_tx_rst, soft_rx_rst
   );

   modport store (
      input  wr_en, rd_en, addr, wdata, snap_on, live_status,
      output rdata, fault_mode, soft_tx_rst, soft_rx_rst
   );
endinterface

// [rtl/csr_regfile.sv]
`timescale 1ns/10ps
`include "eth_csr_defs.svh"

module csr_regfile (
   input  wire logic ref_clk,
   input  wire logic csr_rst_n,
   csr_if.store      bus
);

   logic [`CSR_DATA_W-1:0] link_config_reg;
   logic [`CSR_DATA_W-1:0] scratch_reg;
   logic [`CSR_DATA_W-1:0] tx_counter_status_reg;
   logic [`CSR_DATA_W-1:0] rx_counter_status_reg;
   logic [`CSR_DATA_W-1:0] rdata_reg;
   logic [`CSR_DATA_W-1:0] rdata_next;
   logic [`CSR_DATA_W-1:0] counter_view;
   logic                   hit_config;
   logic                   hit_status;
   logic                   hit_scratch;
   logic                   hit_tx_cnt;
   logic                   hit_rx_cnt;

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   assign hit_config  = (bus.addr == `OFS_LINK_CONFIG);
   assign hit_status  = (bus.addr == `OFS_LINK_STATUS);
   assign hit_scratch = (bus.addr == `OFS_SCRATCH);
   assign hit_tx_cnt  = (bus.addr == `OFS_TX_COUNTER_STATUS);
   assign hit_rx_cnt  = (bus.addr == `OFS_RX_COUNTER_STATUS);

   // shadow-on follows the snapshot level or the software request
   assign counter_view = (tx_counter_status_reg | rx_counter_status_reg)
                       | ({31'h0000_0000, bus.snap_on} << `CNT_SHADOW_ON_BIT)
                       | ((tx_counter_status_reg & 32'h0000_0004) >> 1);

   always_comb begin
      rdata_next = 32'h0000_0000;
      if (hit_config) begin
         rdata_next = link_config_reg;
      end else if (hit_status) begin
         rdata_next = {23'h00_0000, bus.live_status};
      end else if (hit_scratch) begin
         rdata_next = scratch_reg;
      end else if (hit_tx_cnt || hit_rx_cnt) begin
         rdata_next = counter_view;
      end
   end

   // ------------------------------------------------------------
   // storage, cleared only by the global register reset
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!csr_rst_n) begin
         link_config_reg       <= `RST_LINK_CONFIG;
         scratch_reg           <= `RST_SCRATCH;
         tx_counter_status_reg <= `RST_COUNTER_STATUS;
         rx_counter_status_reg <= `RST_COUNTER_STATUS;
         rdata_reg             <= 32'h0000_0000;
      end else begin
         if (bus.wr_en && hit_config) begin
            link_config_reg <= bus.wdata & 32'h0000_0033;
         end
         if (bus.wr_en && hit_scratch) begin
            scratch_reg <= bus.wdata;
         end
         if (bus.wr_en && hit_tx_cnt) begin
            tx_counter_status_reg <= bus.wdata & 32'h0000_0004;
         end
         if (bus.wr_en && hit_rx_cnt) begin
            rx_counter_status_reg <= bus.wdata & 32'h0000_0004;
         end
         if (bus.rd_en) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   assign bus.rdata       = rdata_reg;
   assign bus.fault_mode  = eth_csr_pkg::fault_mode_t'(link_config_reg[1:0]);
   assign bus.soft_tx_rst = link_config_reg[`CFG_SOFT_TX_RST_BIT];
   assign bus.soft_rx_rst = link_config_reg[`CFG_SOFT_RX_RST_BIT];

endmodule

// [rtl/eth_csr_defs.svh]
`ifndef ETH_CSR_DEFS_SVH
`define ETH_CSR_DEFS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define CSR_ADDR_W            12
`define CSR_DATA_W            32
`define OFS_LINK_CONFIG       12'h300
`define OFS_LINK_STATUS       12'h304
`define OFS_SCRATCH           12'h308
`define OFS_TX_COUNTER_STATUS 12'h946
`define OFS_RX_COUNTER_STATUS 12'h946

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CFG_FAULT_MODE_LSB    0
`define CFG_SOFT_TX_RST_BIT   4
`define CFG_SOFT_RX_RST_BIT   5
`define CNT_SHADOW_ON_BIT     1
`define CNT_SHADOW_REQ_BIT    2
`define STAT_CDR_LOCK_BIT     0
`define STAT_LANES_STABLE_BIT 1
`define STAT_BLOCK_LOCK_BIT   2
`define STAT_MARKER_LOCK_BIT  3
`define STAT_PCS_READY_BIT    4
`define STAT_LOCAL_FAULT_BIT  5
`define STAT_REMOTE_FAULT_BIT 6
`define STAT_ERR_RATE_BIT     7
`define STAT_BLOCK_READY_BIT  8
`define STAT_W                9

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_LINK_CONFIG       32'h0000_0002
`define RST_SCRATCH           32'h0000_0000
`define RST_COUNTER_STATUS    32'h0000_0000

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS         50
`define INIT_TIME_NS          800
`define INIT_CYCLES           ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REC_DIV_A             64
`define REC_DIV_B             66

`endif

// [rtl/eth_csr_pkg.sv]
package eth_csr_pkg;

   typedef enum logic [1:0] {
      fault_off,
      fault_one_way,
      fault_both_ways
   } fault_mode_t;

   typedef enum logic [1:0] {
      port_idle,
      port_take,
      port_halt
   } port_state_t;

endpackage

// [rtl/eth_csr_port_and_status.sv]
`timescale 1ns/10ps
`include "eth_csr_defs.svh"


module eth_csr_port_and_status #(
   parameter int LANES       = 4,
   parameter int INIT_CYCLES = `INIT_CYCLES,
   parameter int REC_DIV_A   = `REC_DIV_A,
   parameter int REC_DIV_B   = `REC_DIV_B
) (
   input  wire logic                   ref_clk,
   input  wire logic                   nrst,
   input  wire logic                   csr_rst_n,
   input  wire logic                   tx_rst_n,
   input  wire logic                   rx_rst_n,
   input  wire logic [`CSR_ADDR_W-1:0] reg_addr,
   input  wire logic                   reg_read,
   input  wire logic                   reg_write,
   input  wire logic [`CSR_DATA_W-1:0] reg_writedata,
   output      logic [`CSR_DATA_W-1:0] reg_readdata,
   output      logic                   reg_readdata_valid,
   output      logic                   reg_waitrequest,
   input  wire logic [LANES-1:0]       lane_cdr_locked,
   input  wire logic [LANES-1:0]       lane_tx_ready,
   input  wire logic [LANES-1:0]       lane_block_aligned,
   input  wire logic                   rx_markers_found,
   input  wire logic                   rx_deskew_done,
   input  wire logic [LANES-1:0]       rx_lane_ready,
   input  wire logic                   rx_local_problem,
   input  wire logic                   rx_remote_fault_seen,
   input  wire logic                   rx_ber_state,
   input  wire logic                   stats_snapshot,
   output      logic                   cdr_lock,
   output      logic                   recovered_clock_slow_a,
   output      logic                   recovered_clock_slow_b,
   output      logic                   tx_lanes_stable,
   output      logic                   rx_block_lock,
   output      logic                   receive_marker_aligned,
   output      logic                   rx_pcs_ready,
   output      logic                   local_fault_status,
   output      logic                   remote_fault_status,
   output      logic                   receive_error_rate_high,
   output      logic                   block_ready
);

   csr_if csr ();

   eth_csr_pkg::port_state_t state_reg;
   eth_csr_pkg::port_state_t state_next;
   logic                     valid_reg;
   logic                     valid_next;
   logic                     request;
   logic                     take;
   logic                     port_live;
   logic                     snap_prev_reg;
   logic                     snap_on_reg;
   logic                     snap_rise;
   logic                     snap_fall;
   logic                     tx_held;
   logic                     rx_held;
   logic [15:0]              init_cnt_reg;
   logic                     ready_reg;
   logic [7:0]               div_a_reg;
   logic [7:0]               div_b_reg;
   logic                     slow_a_reg;
   logic                     slow_b_reg;
   logic                     cdr_lock_reg;
   logic                     lanes_stable_reg;
   logic                     block_lock_reg;
   logic                     marker_lock_reg;
   logic                     pcs_ready_reg;
   logic                     local_fault_reg;
   logic                     remote_fault_reg;
   logic                     err_rate_reg;
   logic                     local_fault_next;
   logic                     remote_fault_next;

   // ------------------------------------------------------------
   // access handshake
   // ------------------------------------------------------------
   // port is silent while nrst is low and through the global register reset
   assign port_live = nrst && csr_rst_n;
   assign request   = reg_read || reg_write;
   assign take      = port_live && (state_reg == eth_csr_pkg::port_take) && request;

   // one wait cycle per access; host holds the request meanwhile
   assign reg_waitrequest = !take;

   always_comb begin
      state_next = state_reg;
      valid_next = 1'b0;
      case (state_reg)
         eth_csr_pkg::port_idle: begin
            if (request) begin
               state_next = eth_csr_pkg::port_take;
            end
         end
         eth_csr_pkg::port_take: begin
            state_next = eth_csr_pkg::port_idle;
            valid_next = reg_read;
         end
         default: begin
            state_next = eth_csr_pkg::port_idle;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst || !csr_rst_n) begin
         state_reg <= eth_csr_pkg::port_idle;
         valid_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         valid_reg <= valid_next;
      end
   end

   assign reg_readdata_valid = valid_reg;
   assign reg_readdata       = csr.rdata;

   // ------------------------------------------------------------
   // register file link
   // ------------------------------------------------------------
   assign csr.wr_en = take && reg_write;
   assign csr.rd_en = take && reg_read;
   assign csr.addr  = reg_addr;
   assign csr.wdata = reg_writedata;

   assign csr.snap_on     = snap_on_reg;
   assign csr.live_status = {ready_reg, err_rate_reg, remote_fault_reg, local_fault_reg,
                             pcs_ready_reg, marker_lock_reg, block_lock_reg,
                             lanes_stable_reg, cdr_lock_reg};

   csr_regfile u_regfile (
      .ref_clk   (ref_clk),
      .csr_rst_n (csr_rst_n),
      .bus       (csr.store)
   );

   // ------------------------------------------------------------
   // statistics snapshot
   // ------------------------------------------------------------
   assign snap_rise = stats_snapshot && !snap_prev_reg;
   assign snap_fall = !stats_snapshot && snap_prev_reg;

   always_ff @(posedge ref_clk) begin
      if (!csr_rst_n) begin
         snap_prev_reg <= 1'b0;
         snap_on_reg   <= 1'b0;
      end else begin
         snap_prev_reg <= stats_snapshot;
         if (snap_rise) begin
            snap_on_reg <= 1'b1;
         end else if (snap_fall) begin
            snap_on_reg <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // reset holds and block ready
   // ------------------------------------------------------------
   assign tx_held = !csr_rst_n || !tx_rst_n || csr.soft_tx_rst;
   assign rx_held = !csr_rst_n || !rx_rst_n || csr.soft_rx_rst;

   always_ff @(posedge ref_clk) begin
      if (!nrst || tx_held) begin
         init_cnt_reg <= 16'h0000;
         ready_reg    <= 1'b0;
      end else if (init_cnt_reg == 16'(INIT_CYCLES - 1)) begin
         ready_reg    <= 1'b1;
      end else begin
         init_cnt_reg <= init_cnt_reg + 16'h0001;
      end
   end

   assign block_ready = ready_reg;

   // ------------------------------------------------------------
   // link fault qualification
   // ------------------------------------------------------------
   assign local_fault_next  = rx_local_problem
                            && ((csr.fault_mode == eth_csr_pkg::fault_one_way)
                            ||  (csr.fault_mode == eth_csr_pkg::fault_both_ways));
   assign remote_fault_next = rx_remote_fault_seen
                            && (csr.fault_mode == eth_csr_pkg::fault_both_ways);

   // ------------------------------------------------------------
   // transmit side status
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!nrst || tx_held) begin
         lanes_stable_reg <= 1'b0;
      end else begin
         lanes_stable_reg <= &lane_tx_ready;
      end
   end

   // ------------------------------------------------------------
   // receive side status
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!nrst || rx_held) begin
         cdr_lock_reg     <= 1'b0;
         block_lock_reg   <= 1'b0;
         marker_lock_reg  <= 1'b0;
         pcs_ready_reg    <= 1'b0;
         local_fault_reg  <= 1'b0;
         remote_fault_reg <= 1'b0;
         err_rate_reg     <= 1'b0;
      end else begin
         cdr_lock_reg     <= &lane_cdr_locked;
         block_lock_reg   <= &lane_block_aligned;
         marker_lock_reg  <= rx_markers_found && rx_deskew_done;
         pcs_ready_reg    <= (&rx_lane_ready) && rx_markers_found
                           && rx_deskew_done && (&lane_block_aligned);
         local_fault_reg  <= local_fault_next;
         remote_fault_reg <= remote_fault_next;
         err_rate_reg     <= rx_ber_state;
      end
   end

   assign cdr_lock                = cdr_lock_reg;
   assign tx_lanes_stable         = lanes_stable_reg;
   assign rx_block_lock           = block_lock_reg;
   assign receive_marker_aligned  = marker_lock_reg;
   assign rx_pcs_ready            = pcs_ready_reg;
   assign local_fault_status      = local_fault_reg;
   assign remote_fault_status     = remote_fault_reg;
   assign receive_error_rate_high = err_rate_reg;

   // ------------------------------------------------------------
   // divided recovered-rate enables
   // ------------------------------------------------------------
   // held quiet until lock so no consumer sees a stray pulse
   always_ff @(posedge ref_clk) begin
      if (!nrst || !cdr_lock_reg) begin
         div_a_reg  <= 8'h00;
         div_b_reg  <= 8'h00;
         slow_a_reg <= 1'b0;
         slow_b_reg <= 1'b0;
      end else begin
         slow_a_reg <= (div_a_reg == 8'(REC_DIV_A - 1));
         slow_b_reg <= (div_b_reg == 8'(REC_DIV_B - 1));
         if (div_a_reg == 8'(REC_DIV_A - 1)) begin
            div_a_reg <= 8'h00;
         end else begin
            div_a_reg <= div_a_reg + 8'h01;
         end
         if (div_b_reg == 8'(REC_DIV_B - 1)) begin
            div_b_reg <= 8'h00;
         end else begin
            div_b_reg <= div_b_reg + 8'h01;
         end
      end
   end

   assign recovered_clock_slow_a = slow_a_reg;
   assign recovered_clock_slow_b = slow_b_reg;

endmodule
